// >>> uvb_top.sv
// Line termination and VBUS boost control with an AXI4-Lite register slave.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "uvb_cfg.svh"
module uvb_top
#(
	parameter int ADDR_W = 8,
	parameter int PWM_W = 8
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog comparators on the generated VBUS
	input wire uvb_pkg::uvb_cmp_t vbus_cmp,
	// Line terminations, also the external transceiver controls
	output uvb_pkg::uvb_line_t line_ctrl,
	// Boost supply controls
	output uvb_pkg::uvb_boost_t boost,
	// Module power state
	output logic bus_power_on
);

	typedef struct packed
	{
		uvb_pkg::uvb_regs_t regs;
		uvb_pkg::uvb_line_t line;
		logic target_select;
		logic discharge;
		logic gen_enable;
		logic power_on;
		logic awready;
		logic wready;
		logic aw_full;
		logic w_full;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} uvb_state_t;

	uvb_state_t s;
	uvb_state_t next_s;
	logic pwm_q;
	logic pwm_gate;

	////////////////////////////////////////////////////////////////////////////////////////////

	// Byte-lane merge; reserved bits stay zero through the mask.
	function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] w;
		w = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				w[8*i +: 8] = data[8*i +: 8];
		end
		return w & mask;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] o;
		o = 8'(a);
		return (o == `UVB_OFS_BUS_CONTROL) || (o == `UVB_OFS_DUAL_ROLE) ||
			(o == `UVB_OFS_POWER) || (o == `UVB_OFS_RATE) ||
			(o == `UVB_OFS_PWM_CONTROL) || (o == `UVB_OFS_STATUS);
	endfunction

	// Status word: live terminations, boost pin, comparators and role.
	function automatic logic [31:0] status_word(input uvb_state_t st, input logic pwm,
		input uvb_pkg::uvb_cmp_t cmp);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`UVB_STS_DP_PU] = st.line.dplus_pullup;
		w[`UVB_STS_DP_PD] = st.line.dplus_pulldown;
		w[`UVB_STS_DM_PD] = st.line.dminus_pulldown;
		w[`UVB_STS_PWM] = pwm;
		w[`UVB_STS_ABOVE] = cmp.vbus_above_target;
		w[`UVB_STS_OVERCURRENT] = cmp.overcurrent;
		// The role bit reports the host enable bit of the bus control word.
		w[`UVB_STS_HOST] = st.regs.bus_control[`UVB_BIT_HOST_EN];
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		logic [7:0] wofs;
		logic [7:0] rofs;
		uvb_pkg::uvb_regs_t r;
		next_s = s;
		wofs = 8'(s.awaddr);
		rofs = 8'(s_axi_araddr);
		r = s.regs;

		// Address and data are taken in either order and held until both are in.
		if (s_axi_awvalid && s.awready)
		begin
			next_s.aw_full = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready)
		begin
			next_s.w_full = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;

		if (s.aw_full && s.w_full && !s.bvalid)
		begin
			next_s.aw_full = 1'b0;
			next_s.w_full = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = is_mapped(s.awaddr) ? `UVB_RESP_OKAY : `UVB_RESP_SLVERR;
			// The status word is read-only; writes to it are answered and dropped.
			unique case (wofs)
				`UVB_OFS_BUS_CONTROL:
					next_s.regs.bus_control = merge_word(s.regs.bus_control, s.wdata,
						s.wstrb, `UVB_MASK_BUS_CONTROL);
				`UVB_OFS_DUAL_ROLE:
					next_s.regs.dual_role = merge_word(s.regs.dual_role, s.wdata,
						s.wstrb, `UVB_MASK_DUAL_ROLE);
				`UVB_OFS_POWER:
					next_s.regs.power = merge_word(s.regs.power, s.wdata,
						s.wstrb, `UVB_MASK_POWER);
				`UVB_OFS_RATE:
					next_s.regs.rate = merge_word(s.regs.rate, s.wdata,
						s.wstrb, `UVB_MASK_RATE);
				`UVB_OFS_PWM_CONTROL:
					next_s.regs.pwm_control = merge_word(s.regs.pwm_control, s.wdata,
						s.wstrb, `UVB_MASK_PWM_CONTROL);
				default:
					next_s.regs = next_s.regs;
			endcase
		end

		// Reads answer one cycle after the address is taken.
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = is_mapped(s_axi_araddr) ? `UVB_RESP_OKAY : `UVB_RESP_SLVERR;
			unique case (rofs)
				`UVB_OFS_BUS_CONTROL: next_s.rdata = s.regs.bus_control;
				`UVB_OFS_DUAL_ROLE: next_s.rdata = s.regs.dual_role;
				`UVB_OFS_POWER: next_s.rdata = s.regs.power;
				`UVB_OFS_RATE: next_s.rdata = s.regs.rate;
				`UVB_OFS_PWM_CONTROL: next_s.rdata = s.regs.pwm_control;
				`UVB_OFS_STATUS: next_s.rdata = status_word(s, pwm_q, vbus_cmp);
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end

		next_s.awready = !next_s.aw_full && !next_s.bvalid;
		next_s.wready = !next_s.w_full && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;

		// Terminations follow the registers as they stand after this cycle's write.
		r = next_s.regs;
		if (r.dual_role[`UVB_BIT_DUAL_EN])
		begin
			next_s.line.dplus_pullup = r.dual_role[`UVB_BIT_DP_PU];
			next_s.line.dplus_pulldown = r.dual_role[`UVB_BIT_DP_PD];
			next_s.line.dminus_pulldown = r.dual_role[`UVB_BIT_DM_PD];
		end
		else
		begin
			// Host role owns the line, so the device pull-up gives way to the pull-downs.
			next_s.line.dplus_pullup = r.bus_control[`UVB_BIT_ENGINE_EN] &&
				!r.bus_control[`UVB_BIT_HOST_EN];
			next_s.line.dplus_pulldown = r.bus_control[`UVB_BIT_HOST_EN];
			next_s.line.dminus_pulldown = r.bus_control[`UVB_BIT_HOST_EN];
		end
		next_s.target_select = r.dual_role[`UVB_BIT_TARGET_SEL];
		next_s.discharge = r.dual_role[`UVB_BIT_DISCHARGE];
		next_s.gen_enable = r.dual_role[`UVB_BIT_VBUS_GEN];
		next_s.power_on = r.power[`UVB_BIT_POWER];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
			s.regs <= {5{`UVB_RST_REG}};
		end
		else
		begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////

	// Pulses stop while the output is above target or the current limit trips.
	assign pwm_gate = s.regs.pwm_control[`UVB_BIT_PWM_EN] && s.gen_enable &&
		!vbus_cmp.vbus_above_target && !vbus_cmp.overcurrent;

	uvb_pwm #(
		.WIDTH(PWM_W)
	) u_pwm (
		.aclk(aclk),
		.aresetn(aresetn),
		.counter_enable(s.regs.pwm_control[`UVB_BIT_CNT_EN]),
		.period(PWM_W'(s.regs.rate[`UVB_RATE_PERIOD_MSB:`UVB_RATE_PERIOD_LSB])),
		.duty(PWM_W'(s.regs.rate[`UVB_RATE_DUTY_MSB:`UVB_RATE_DUTY_LSB])),
		.polarity(s.regs.pwm_control[`UVB_BIT_POL]),
		.gate(pwm_gate),
		.pwm_out(pwm_q)
	);

	////////////////////////////////////////////////////////////////////////////////////////////

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign line_ctrl = s.line;
	assign boost.pwm_out = pwm_q;
	assign boost.target_select = s.target_select;
	assign boost.discharge = s.discharge;
	assign boost.gen_enable = s.gen_enable;
	assign bus_power_on = s.power_on;

endmodule

// >>> uvb_cfg.svh
// Register map, field positions and reset values of the line and VBUS boost control block.
`ifndef UVB_CFG_SVH
`define UVB_CFG_SVH

`define UVB_OFS_BUS_CONTROL 8'h00
`define UVB_OFS_DUAL_ROLE 8'h04
`define UVB_OFS_POWER 8'h08
`define UVB_OFS_RATE 8'h0C
`define UVB_OFS_PWM_CONTROL 8'h10
`define UVB_OFS_STATUS 8'h14

`define UVB_BIT_ENGINE_EN 0
`define UVB_BIT_HOST_EN 3
`define UVB_BIT_DISCHARGE 0
`define UVB_BIT_TARGET_SEL 1
`define UVB_BIT_DUAL_EN 2
`define UVB_BIT_VBUS_GEN 3
`define UVB_BIT_DM_PD 4
`define UVB_BIT_DP_PD 5
`define UVB_BIT_DP_PU 7
`define UVB_BIT_POWER 0
`define UVB_BIT_CNT_EN 8
`define UVB_BIT_POL 9
`define UVB_BIT_PWM_EN 15
`define UVB_RATE_PERIOD_MSB 7
`define UVB_RATE_PERIOD_LSB 0
`define UVB_RATE_DUTY_MSB 15
`define UVB_RATE_DUTY_LSB 8

`define UVB_STS_DP_PU 0
`define UVB_STS_DP_PD 1
`define UVB_STS_DM_PD 2
`define UVB_STS_PWM 3
`define UVB_STS_ABOVE 4
`define UVB_STS_OVERCURRENT 5
`define UVB_STS_HOST 6

`define UVB_MASK_BUS_CONTROL 32'h0000_0009
`define UVB_MASK_DUAL_ROLE 32'h0000_00BF
`define UVB_MASK_POWER 32'h0000_0001
`define UVB_MASK_RATE 32'h0000_FFFF
`define UVB_MASK_PWM_CONTROL 32'h0000_8300
`define UVB_RST_REG 32'h0000_0000

`define UVB_RESP_OKAY 2'h0
`define UVB_RESP_SLVERR 2'h2

`endif

// >>> uvb_pkg.sv
// Types shared by the line and VBUS boost control block.
package uvb_pkg;

	typedef struct packed
	{
		logic dplus_pullup;
		logic dplus_pulldown;
		logic dminus_pulldown;
	} uvb_line_t;

	typedef struct packed
	{
		logic vbus_above_target;
		logic overcurrent;
	} uvb_cmp_t;

	typedef struct packed
	{
		logic pwm_out;
		logic target_select;
		logic discharge;
		logic gen_enable;
	} uvb_boost_t;

	typedef struct packed
	{
		logic [31:0] bus_control;
		logic [31:0] dual_role;
		logic [31:0] power;
		logic [31:0] rate;
		logic [31:0] pwm_control;
	} uvb_regs_t;

endpackage

// >>> uvb_pwm.sv
// Boost PWM generator with a period, a duty, a polarity and a run gate.
`timescale 1ns/1ps
module uvb_pwm
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Settings
	input wire logic counter_enable,
	input wire logic [WIDTH-1:0] period,
	input wire logic [WIDTH-1:0] duty,
	input wire logic polarity,
	input wire logic gate,
	// Output
	output logic pwm_out
);

	typedef struct packed
	{
		logic [WIDTH-1:0] count;
		logic out;
	} uvb_pwm_state_t;

	uvb_pwm_state_t s;
	uvb_pwm_state_t next_s;

	always_comb
	begin
		next_s = s;
		// A stopped counter freezes so the waveform resumes without a glitch.
		if (counter_enable)
		begin
			if (s.count >= period)
				next_s.count = '0;
			else
				next_s.count = s.count + 1'b1;
		end
		// Gated off, the pin rests at its inactive level, which the polarity sets.
		if (gate)
			next_s.out = (s.count < duty) ^ polarity;
		else
			next_s.out = polarity;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign pwm_out = s.out;

endmodule

// >>> uvb_checker.sv
// Bus handshake and boost output checks for the line and VBUS boost control block.
`timescale 1ns/1ps
module uvb_chk
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Boost side
	input wire uvb_pkg::uvb_cmp_t vbus_cmp,
	input wire uvb_pkg::uvb_boost_t boost
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Two idle samples are needed, since the output lags the gate by one cycle.
	sequence s_gen_idle;
		!boost.gen_enable [*2] ##0 $changed(boost.pwm_out);
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during response");
	a_idle_level: assert property (s_gen_idle |=> $stable(boost.pwm_out) [*2])
		else $error("boost output moves while generation off");
	a_cmp_gate: assert property ((vbus_cmp.overcurrent || vbus_cmp.vbus_above_target) [*3] |->
		$stable(boost.pwm_out)) else $error("boost output moves while comparator trips");
endmodule
bind uvb_top uvb_chk chk (.*);

// >>> uvb_vbus_model.sv
// Model of the external VBUS switch-mode supply and its comparators.
`timescale 1ns/1ps
module uvb_vbus_model
#(
	parameter int LIMIT = 20
)
(
	// Clock
	input wire logic aclk,
	// Boost controls and a commanded overload
	input wire uvb_pkg::uvb_boost_t boost,
	input wire logic fault,
	// Comparator outputs
	output uvb_pkg::uvb_cmp_t vbus_cmp
);
	int charge = 0;
	logic last = 1'b0;
	initial vbus_cmp = '0;
	// Charge grows one step per switching pulse and drains once generation stops.
	always @(posedge aclk)
	begin
		last <= boost.pwm_out;
		if (!boost.gen_enable || boost.discharge)
			charge <= 0;
		else if (boost.pwm_out && !last)
			charge <= charge + 1;
		vbus_cmp.vbus_above_target <= (charge >= LIMIT);
		vbus_cmp.overcurrent <= fault;
	end
endmodule

// >>> tb_top.sv
// Self-checking testbench for the line and VBUS boost control block.
`timescale 1ns/1ps
`include "uvb_cfg.svh"
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fault = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_power_on;
	uvb_pkg::uvb_cmp_t vbus_cmp;
	uvb_pkg::uvb_line_t line_ctrl;
	uvb_pkg::uvb_boost_t boost;
	int errors = 0;
	int n_tests = 0;
	logic [31:0] h;
	uvb_top dut (.*);
	uvb_vbus_model vm (.*);
	initial forever #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// A nonzero lag holds the response ready low for that many edges.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0,
		input int lag = 0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		while (!(s_axi_bvalid && s_axi_bready))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (lag > 0)
				lag--;
			if (lag == 0)
				s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] e = 2'h0, input int lag = 0);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		while (!(s_axi_rvalid && s_axi_rready))
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (lag > 0)
				lag--;
			if (lag == 0)
				s_axi_rready <= 1'b1;
		end
		q = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk(s_axi_rresp, e);
	endtask
	// Counts the high samples of the boost output over eight cycles.
	task automatic hi();
		h = 32'h0;
		repeat (8)
		begin
			@(posedge aclk);
			h += boost.pwm_out;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] m [5] = '{`UVB_MASK_BUS_CONTROL, `UVB_MASK_DUAL_ROLE, `UVB_MASK_POWER,
			`UVB_MASK_RATE, `UVB_MASK_PWM_CONTROL};
		for (int i = 0; i < 6; i++)
		begin
			rd(8'(4 * i));
			chk(q, 32'h0);
		end
		for (int i = 0; i < 5; i++)
		begin
			wr(8'(4 * i), 32'hFFFF_FFFF);
			rd(8'(4 * i));
			chk(q, m[i]);
			wr(8'(4 * i), 32'h0);
		end
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h14);
		chk(q, 32'h0);
		wr(8'h18, 32'h1, 2'h2);
		rd(8'h18, 2'h2);
		chk(q, 32'h0);
		wr(8'h0C, 32'h1234_5678, 2'h0, 3);
		rd(8'h0C, 2'h0, 3);
		chk(q, 32'h0000_5678);
	endtask
	task automatic t_lines();
		logic [7:0] bc [9] = '{8'h01, 8'h09, 8'h08, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [7:0] du [9] = '{8'h00, 8'h00, 8'h00, 8'hB0, 8'h04, 8'h84, 8'h24, 8'h14, 8'hB4};
		logic [2:0] ex [9] = '{3'h4, 3'h3, 3'h3, 3'h4, 3'h0, 3'h4, 3'h2, 3'h1, 3'h7};
		for (int i = 0; i < 9; i++)
		begin
			wr(8'h00, {24'h0, bc[i]});
			wr(8'h04, {24'h0, du[i]});
			chk(line_ctrl, ex[i]);
			rd(8'h14);
			chk(q[2:0], {ex[i][0], ex[i][1], ex[i][2]});
			chk(q[6], bc[i][3]);
		end
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h0);
	endtask
	task automatic t_boost();
		logic [31:0] p;
		wr(8'h08, 32'h1);
		chk(bus_power_on, 1'b1);
		rd(8'h04);
		chk(q[0], 1'b0);
		wr(8'h0C, 32'h0000_0103);
		for (int i = 0; i < 2; i++)
		begin
			p = i ? 32'h0000_0200 : 32'h0;
			wr(8'h10, p);
			wr(8'h04, 32'h2);
			chk(boost.target_select, 1'b1);
			wr(8'h10, p | 32'h0000_0100);
			wr(8'h10, p | 32'h0000_8100);
			chk(boost.pwm_out, p[9]);
			wr(8'h04, 32'hA);
			chk(boost.gen_enable, 1'b1);
			repeat (4) @(posedge aclk);
			hi();
			chk(h, i ? 6 : 2);
			wr(8'h10, p | 32'h0000_8000);
			hi();
			chk(h == 0 || h == 8, 1'b1);
			wr(8'h10, p | 32'h0000_0100);
			hi();
			chk(h, 8 * i);
			rd(8'h14);
			chk(q[3], p[9]);
			wr(8'h04, 32'h0);
		end
		wr(8'h10, 32'h0);
	endtask
	task automatic t_regulate();
		wr(8'h00, 32'h8);
		wr(8'h10, 32'h0000_8100);
		wr(8'h04, 32'h8);
		repeat (120) @(posedge aclk);
		hi();
		chk(h, 0);
		rd(8'h14);
		chk(q[6:3], 4'hA);
		wr(8'h04, 32'h0);
		fault <= 1'b1;
		wr(8'h04, 32'h8);
		repeat (4) @(posedge aclk);
		hi();
		chk(h, 0);
		rd(8'h14);
		chk(q[6:3], 4'hC);
		fault <= 1'b0;
		repeat (4) @(posedge aclk);
		hi();
		chk(h, 2);
		wr(8'h04, 32'h1);
		chk(boost.discharge, 1'b1);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		chk(line_ctrl, 3'h0);
		t_regs();
		t_lines();
		t_boost();
		t_regulate();
		end_of_test();
	end
	// The whole run takes a few hundred cycles, so this margin only catches a hang.
	initial
	begin
		#300000;
		errors++;
		end_of_test();
	end
endmodule
